// File: rtl/io_space_pkg.sv
// Constants for the I/O register space decode block
package io_space_pkg;
    localparam int unsigned ADDR_W      = 6;
    localparam int unsigned DATA_W      = 8;
    localparam logic [5:0]  BIT_OP_LAST = 6'h1f;
    // Register offsets
    localparam logic [5:0] ADC_CONTROL_STATUS_B      = 6'h03;
    localparam logic [5:0] ADC_RESULT_LOW            = 6'h04;
    localparam logic [5:0] ADC_RESULT_HIGH           = 6'h05;
    localparam logic [5:0] ADC_CONTROL_STATUS_A      = 6'h06;
    localparam logic [5:0] ADC_CHANNEL_SELECT        = 6'h07;
    localparam logic [5:0] COMPARATOR_CONTROL_STATUS = 6'h08;
    localparam logic [5:0] SERIAL_IFACE_CONTROL      = 6'h0d;
    localparam logic [5:0] SERIAL_IFACE_STATUS       = 6'h0e;
    localparam logic [5:0] SERIAL_IFACE_DATA         = 6'h0f;
    localparam logic [5:0] SERIAL_IFACE_BUFFER       = 6'h10;
    localparam logic [5:0] GENERAL_PURPOSE_0         = 6'h11;
    localparam logic [5:0] GENERAL_PURPOSE_1         = 6'h12;
    localparam logic [5:0] GENERAL_PURPOSE_2         = 6'h13;
    localparam logic [5:0] DIGITAL_INPUT_DISABLE     = 6'h14;
    localparam logic [5:0] PIN_CHANGE_MASK           = 6'h15;
    localparam logic [5:0] PORT_B_INPUT_PINS         = 6'h16;
    localparam logic [5:0] PORT_B_DIRECTION          = 6'h17;
    localparam logic [5:0] PORT_B_OUTPUT             = 6'h18;
    localparam logic [5:0] EEPROM_CONTROL            = 6'h1c;
    localparam logic [5:0] EEPROM_DATA               = 6'h1d;
    localparam logic [5:0] EEPROM_ADDRESS_LOW        = 6'h1e;
    localparam logic [5:0] EEPROM_ADDRESS_HIGH       = 6'h1f;
    localparam logic [5:0] POWER_REDUCTION           = 6'h20;
    localparam logic [5:0] WATCHDOG_CONTROL          = 6'h21;
    localparam logic [5:0] DEBUG_DATA                = 6'h22;
    localparam logic [5:0] DEAD_TIME_PRESCALER       = 6'h23;
    localparam logic [5:0] DEAD_TIME_B               = 6'h24;
    localparam logic [5:0] DEAD_TIME_A               = 6'h25;
    localparam logic [5:0] CLOCK_PRESCALE            = 6'h26;
    localparam logic [5:0] PLL_CONTROL_STATUS        = 6'h27;
    localparam logic [5:0] TIMER0_COMPARE_B          = 6'h28;
    localparam logic [5:0] TIMER0_COMPARE_A          = 6'h29;
    localparam logic [5:0] TIMER0_CONTROL_A          = 6'h2a;
    localparam logic [5:0] TIMER1_COMPARE_B          = 6'h2b;
    localparam logic [5:0] GENERAL_TIMER_CONTROL     = 6'h2c;
    localparam logic [5:0] TIMER1_COMPARE_C          = 6'h2d;
    localparam logic [5:0] TIMER1_COMPARE_A          = 6'h2e;
    localparam logic [5:0] TIMER1_COUNT              = 6'h2f;
    localparam logic [5:0] TIMER1_CONTROL            = 6'h30;
    localparam logic [5:0] OSCILLATOR_CALIBRATION    = 6'h31;
    localparam logic [5:0] TIMER0_COUNT              = 6'h32;
    localparam logic [5:0] TIMER0_CONTROL_B          = 6'h33;
    localparam logic [5:0] RESET_CAUSE_FLAGS         = 6'h34;
    localparam logic [5:0] CORE_CONTROL              = 6'h35;
    localparam logic [5:0] SELF_PROGRAM_CONTROL      = 6'h37;
    localparam logic [5:0] TIMER_INTERRUPT_FLAGS     = 6'h38;
    localparam logic [5:0] TIMER_INTERRUPT_MASK      = 6'h39;
    localparam logic [5:0] EXTERNAL_INTERRUPT_FLAGS  = 6'h3a;
    localparam logic [5:0] EXTERNAL_INTERRUPT_MASK   = 6'h3b;
    localparam logic [5:0] STACK_POINTER_LOW         = 6'h3d;
    localparam logic [5:0] STACK_POINTER_HIGH        = 6'h3e;
    localparam logic [5:0] PROCESSOR_STATUS_FLAGS    = 6'h3f;
    localparam logic [7:0] STORE_RESET = 8'h00;
    // Access kinds issued by the core
    typedef enum logic [2:0] {
        OP_NONE              = 3'b000,
        OP_WRITE             = 3'b001,
        OP_SET_SINGLE_IO_BIT = 3'b010,
        OP_CLR_SINGLE_IO_BIT = 3'b011,
        OP_SKIP_IF_BIT_SET   = 3'b100,
        OP_SKIP_IF_BIT_CLEAR = 3'b101
    } io_op_t;
endpackage

// File: rtl/io_register_space_bit_access.sv
// I/O register space decode with single-bit access and flag handling
// Notes on behaviour
// R1: Software writes zero to reserved bits of any register it writes.
// R2: Software never writes to a reserved I/O address.
// R3: Bit set and bit clear work at 0x00 to 0x1F and nowhere higher.
// R4: In 0x00 to 0x1F the core may test one bit and skip on set or clear.
// R5: Status flags clear on a written one and keep their state on a zero.
// R6: A bit set or clear changes only its bit; a clear leaves a flag as is, a set on a flag clears it.
// R7: Locations are 8 bits, reserved bits read zero and ignore writes.
`timescale 1ns/1ps
module io_register_space_bit_access
    import io_space_pkg::*;
#(
    // Sizes
    parameter int unsigned LOCATIONS = 2 ** ADDR_W,
    parameter int unsigned BITS      = DATA_W
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Core access port
    input  wire io_op_t      io_op,
    input  wire logic [5:0]  io_addr,
    input  wire logic [2:0]  io_bit,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_skip,
    output logic             io_refused,
    // Peripheral side: live values and flag set events
    input  wire logic [7:0]  periph_rdata [64],
    input  wire logic [7:0]  flag_set [64],
    // Stored values towards peripherals
    output logic      [7:0]  reg_value [64]
);
    // Size check
    if (LOCATIONS != 2 ** ADDR_W || BITS != DATA_W) begin : g_size_bad
        $error("unsupported location count or width");
    end

    // Implemented bits per location, zero for reserved
    function automatic logic [7:0] impl_mask(input logic [5:0] a);
        unique case (a)
            6'h00, 6'h01, 6'h02, 6'h09, 6'h0a, 6'h0b, 6'h0c,
            6'h19, 6'h1a, 6'h1b, 6'h36, 6'h3c: impl_mask = 8'h00;
            ADC_CONTROL_STATUS_B:      impl_mask = 8'he7;
            COMPARATOR_CONTROL_STATUS: impl_mask = 8'hfb;
            DIGITAL_INPUT_DISABLE, PIN_CHANGE_MASK, PORT_B_INPUT_PINS,
            PORT_B_DIRECTION, PORT_B_OUTPUT: impl_mask = 8'h3f;
            EEPROM_CONTROL:        impl_mask = 8'h3f;
            EEPROM_ADDRESS_HIGH:   impl_mask = 8'h01;
            POWER_REDUCTION:       impl_mask = 8'h0f;
            DEAD_TIME_PRESCALER:   impl_mask = 8'h03;
            CLOCK_PRESCALE:        impl_mask = 8'h8f;
            PLL_CONTROL_STATUS:    impl_mask = 8'h87;
            TIMER0_CONTROL_A:      impl_mask = 8'hf3;
            TIMER0_CONTROL_B:      impl_mask = 8'hcf;
            RESET_CAUSE_FLAGS:     impl_mask = 8'h0f;
            SELF_PROGRAM_CONTROL:  impl_mask = 8'h3f;
            TIMER_INTERRUPT_FLAGS, TIMER_INTERRUPT_MASK: impl_mask = 8'h7e;
            EXTERNAL_INTERRUPT_FLAGS,
            EXTERNAL_INTERRUPT_MASK: impl_mask = 8'h60;
            STACK_POINTER_HIGH:    impl_mask = 8'h03;
            default:               impl_mask = 8'hff;
        endcase
    endfunction

    // Bits cleared by writing one
    function automatic logic [7:0] w1c_mask(input logic [5:0] a);
        unique case (a)
            ADC_CONTROL_STATUS_A:      w1c_mask = 8'h10;
            COMPARATOR_CONTROL_STATUS: w1c_mask = 8'h10;
            SERIAL_IFACE_STATUS:       w1c_mask = 8'he0;
            WATCHDOG_CONTROL:          w1c_mask = 8'h80;
            RESET_CAUSE_FLAGS:         w1c_mask = 8'h0f;
            TIMER_INTERRUPT_FLAGS:     w1c_mask = 8'h7e;
            EXTERNAL_INTERRUPT_FLAGS:  w1c_mask = 8'h60;
            default:                   w1c_mask = 8'h00;
        endcase
    endfunction

    // Bits that read the peripheral's live value
    function automatic logic [7:0] live_mask(input logic [5:0] a);
        unique case (a)
            ADC_RESULT_LOW, ADC_RESULT_HIGH, SERIAL_IFACE_BUFFER,
            PORT_B_INPUT_PINS: live_mask = 8'hff;
            COMPARATOR_CONTROL_STATUS: live_mask = 8'h20;
            PLL_CONTROL_STATUS:        live_mask = 8'h01;
            default:                   live_mask = 8'h00;
        endcase
    endfunction

    logic       low_space;
    logic [7:0] sel_bit;
    logic [7:0] cur_value;

    assign low_space = (io_addr <= BIT_OP_LAST);
    assign sel_bit   = 8'h01 << io_bit;

    // Read mux, reserved bits zero
    always_comb begin
        cur_value = ((reg_value[io_addr] & ~live_mask(io_addr))
                    | (periph_rdata[io_addr] & live_mask(io_addr)))
                    & impl_mask(io_addr); // R7
        io_rdata  = cur_value;
    end

    // Bit test and skip
    always_comb begin
        io_skip = 1'b0;
        if (low_space) begin
            if (io_op == OP_SKIP_IF_BIT_SET) begin
                io_skip = |(cur_value & sel_bit); // R4
            end else if (io_op == OP_SKIP_IF_BIT_CLEAR) begin
                io_skip = ~|(cur_value & sel_bit); // R4
            end
        end
    end

    // Bit operations above the low space are refused
    always_comb begin
        io_refused = !low_space && (io_op == OP_SET_SINGLE_IO_BIT
                     || io_op == OP_CLR_SINGLE_IO_BIT
                     || io_op == OP_SKIP_IF_BIT_SET
                     || io_op == OP_SKIP_IF_BIT_CLEAR); // R3
    end

    // Per-location storage
    for (genvar g = 0; g < LOCATIONS; g++) begin : g_loc
        localparam logic [5:0] A = 6'(g);
        logic       hit;
        logic [7:0] wr_mask;
        logic [7:0] wr_data;
        logic [7:0] clr_flags;
        logic [7:0] next_value;
        assign hit = (io_addr == A);
        always_comb begin
            wr_mask = 8'h00;
            wr_data = 8'h00;
            clr_flags = 8'h00;
            if (hit) begin
                unique case (io_op)
                    OP_WRITE: begin
                        wr_mask   = impl_mask(A) & ~w1c_mask(A); // R7
                        wr_data   = io_wdata;
                        clr_flags = io_wdata & w1c_mask(A); // R5
                    end
                    OP_SET_SINGLE_IO_BIT: begin
                        if (A <= BIT_OP_LAST) begin // R3
                            wr_mask   = sel_bit & impl_mask(A)
                                        & ~w1c_mask(A); // R6
                            wr_data   = 8'hff;
                            clr_flags = sel_bit & w1c_mask(A); // R6
                        end
                    end
                    OP_CLR_SINGLE_IO_BIT: begin
                        if (A <= BIT_OP_LAST) begin // R3
                            wr_mask = sel_bit & impl_mask(A)
                                      & ~w1c_mask(A); // R6
                            wr_data = 8'h00;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            next_value = (reg_value[g] & ~wr_mask) | (wr_data & wr_mask);
            next_value = next_value & ~(clr_flags & ~flag_set[g]);
            next_value = next_value | (flag_set[g] & w1c_mask(A)); // R5
            next_value = next_value & impl_mask(A);
        end
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                reg_value[g] <= STORE_RESET;
            end else begin
                reg_value[g] <= next_value;
            end
        end
    end

    // Checks
    sequence bit_op_low_s;
        io_op == OP_SET_SINGLE_IO_BIT && io_addr <= BIT_OP_LAST;
    endsequence

    sequence clr_op_low_s;
        io_op == OP_CLR_SINGLE_IO_BIT && io_addr <= BIT_OP_LAST;
    endsequence

    sequence bit_op_high_s;
        (io_op == OP_SET_SINGLE_IO_BIT || io_op == OP_CLR_SINGLE_IO_BIT)
        && io_addr > BIT_OP_LAST;
    endsequence

    sequence test_op_high_s;
        (io_op == OP_SKIP_IF_BIT_SET || io_op == OP_SKIP_IF_BIT_CLEAR)
        && io_addr > BIT_OP_LAST;
    endsequence

    sequence quiet_loc_s;
        flag_set[io_addr] == 8'h00;
    endsequence

    sequence plain_bit_s;
        (impl_mask(io_addr) & ~w1c_mask(io_addr) & sel_bit) != 8'h00;
    endsequence

    sequence flag_bit_s;
        (w1c_mask(io_addr) & sel_bit) != 8'h00;
    endsequence

    bit_op_high_a: assert property ( // R3
        @(posedge core_clk) disable iff (!rst_b)
        bit_op_high_s and quiet_loc_s
        |=> reg_value[$past(io_addr)] == $past(reg_value[io_addr]))
        else $error("bit op changed a high address");

    high_refused_a: assert property ( // R3
        @(posedge core_clk) disable iff (!rst_b)
        bit_op_high_s
        |-> io_refused)
        else $error("high bit op not refused");

    test_refused_a: assert property ( // R3
        @(posedge core_clk) disable iff (!rst_b)
        test_op_high_s
        |-> io_refused && !io_skip)
        else $error("high bit test not refused");

    low_accepted_a: assert property ( // R3
        @(posedge core_clk) disable iff (!rst_b)
        io_addr <= BIT_OP_LAST
        |-> !io_refused)
        else $error("low access refused");

    plain_access_a: assert property ( // R3
        @(posedge core_clk) disable iff (!rst_b)
        io_op == OP_NONE || io_op == OP_WRITE
        |-> !io_refused)
        else $error("plain access refused");

    set_bit_a: assert property ( // R3
        @(posedge core_clk) disable iff (!rst_b)
        bit_op_low_s and quiet_loc_s and plain_bit_s
        |=> (reg_value[$past(io_addr)] & $past(sel_bit)) != 8'h00)
        else $error("bit set did not land");

    clr_bit_a: assert property ( // R3
        @(posedge core_clk) disable iff (!rst_b)
        clr_op_low_s and quiet_loc_s and plain_bit_s
        |=> (reg_value[$past(io_addr)] & $past(sel_bit)) == 8'h00)
        else $error("bit clear did not land");

    skip_set_a: assert property ( // R4
        @(posedge core_clk) disable iff (!rst_b)
        io_op == OP_SKIP_IF_BIT_SET && low_space
        |-> io_skip == io_rdata[io_bit])
        else $error("skip on set wrong");

    skip_clear_a: assert property ( // R4
        @(posedge core_clk) disable iff (!rst_b)
        io_op == OP_SKIP_IF_BIT_CLEAR && low_space
        |-> io_skip != io_rdata[io_bit])
        else $error("skip on clear wrong");

    skip_idle_a: assert property ( // R4
        @(posedge core_clk) disable iff (!rst_b)
        io_op != OP_SKIP_IF_BIT_SET && io_op != OP_SKIP_IF_BIT_CLEAR
        |-> !io_skip)
        else $error("skip without a test");

    flag_clear_a: assert property ( // R5
        @(posedge core_clk) disable iff (!rst_b)
        io_op == OP_WRITE && io_addr == TIMER_INTERRUPT_FLAGS
        && flag_set[TIMER_INTERRUPT_FLAGS] == 8'h00
        |=> (reg_value[TIMER_INTERRUPT_FLAGS]
        & $past(io_wdata) & 8'h7e) == 8'h00)
        else $error("flag not cleared by one");

    flag_keep_a: assert property ( // R5
        @(posedge core_clk) disable iff (!rst_b)
        io_op == OP_WRITE && io_addr == EXTERNAL_INTERRUPT_FLAGS
        && flag_set[EXTERNAL_INTERRUPT_FLAGS] == 8'h00
        |=> (reg_value[EXTERNAL_INTERRUPT_FLAGS] & ~$past(io_wdata))
        == ($past(reg_value[EXTERNAL_INTERRUPT_FLAGS]) & ~$past(io_wdata)))
        else $error("flag lost on zero write");

    set_flag_a: assert property ( // R6
        @(posedge core_clk) disable iff (!rst_b)
        bit_op_low_s and quiet_loc_s and flag_bit_s
        |=> (reg_value[$past(io_addr)] & $past(sel_bit)) == 8'h00)
        else $error("bit set left its flag");

    clr_flag_a: assert property ( // R6
        @(posedge core_clk) disable iff (!rst_b)
        clr_op_low_s and quiet_loc_s and flag_bit_s
        |=> (reg_value[$past(io_addr)] & $past(sel_bit))
        == ($past(reg_value[io_addr]) & $past(sel_bit)))
        else $error("bit clear touched a flag");

    single_bit_a: assert property ( // R6
        @(posedge core_clk) disable iff (!rst_b)
        bit_op_low_s and quiet_loc_s
        |=> ((reg_value[$past(io_addr)] ^ $past(reg_value[io_addr]))
        & ~$past(sel_bit)) == 8'h00)
        else $error("bit op touched other bits");

    clr_single_a: assert property ( // R6
        @(posedge core_clk) disable iff (!rst_b)
        clr_op_low_s and quiet_loc_s
        |=> ((reg_value[$past(io_addr)] ^ $past(reg_value[io_addr]))
        & ~$past(sel_bit)) == 8'h00)
        else $error("bit clear touched other bits");

    reserved_zero_a: assert property ( // R7
        @(posedge core_clk) disable iff (!rst_b)
        (io_rdata & ~impl_mask(io_addr)) == 8'h00)
        else $error("reserved bit read nonzero");

    live_pins_a: assert property ( // R7
        @(posedge core_clk) disable iff (!rst_b)
        io_addr == PORT_B_INPUT_PINS
        |-> io_rdata == (periph_rdata[PORT_B_INPUT_PINS] & 8'h3f))
        else $error("pin read not live");

    live_compare_a: assert property ( // R7
        @(posedge core_clk) disable iff (!rst_b)
        io_addr == COMPARATOR_CONTROL_STATUS
        |-> io_rdata[5] == periph_rdata[COMPARATOR_CONTROL_STATUS][5])
        else $error("comparator bit not live");

    // Per-location checks
    for (genvar c = 0; c < LOCATIONS; c++) begin : g_chk
        localparam logic [5:0] L = 6'(c);

        store_hole_a: assert property ( // R7
            @(posedge core_clk) disable iff (!rst_b)
            (reg_value[c] & ~impl_mask(L)) == 8'h00)
            else $error("reserved bit stored");

        flag_wins_a: assert property ( // R5
            @(posedge core_clk) disable iff (!rst_b)
            (flag_set[c] & w1c_mask(L)) != 8'h00
            |=> (reg_value[c] & $past(flag_set[c]) & w1c_mask(L))
            == ($past(flag_set[c]) & w1c_mask(L)))
            else $error("flag set lost");

        idle_hold_a: assert property ( // R7
            @(posedge core_clk) disable iff (!rst_b)
            io_op == OP_NONE && flag_set[c] == 8'h00
            |=> reg_value[c] == $past(reg_value[c]))
            else $error("value moved while idle");

        other_loc_a: assert property ( // R6
            @(posedge core_clk) disable iff (!rst_b)
            io_addr != L && flag_set[c] == 8'h00
            |=> reg_value[c] == $past(reg_value[c]))
            else $error("access hit another location");

        write_land_a: assert property ( // R7
            @(posedge core_clk) disable iff (!rst_b)
            io_op == OP_WRITE && io_addr == L
            |=> (reg_value[c] & impl_mask(L) & ~w1c_mask(L))
            == ($past(io_wdata) & impl_mask(L) & ~w1c_mask(L)))
            else $error("write did not land");

        zero_keep_a: assert property ( // R5
            @(posedge core_clk) disable iff (!rst_b)
            io_op == OP_WRITE && io_addr == L && flag_set[c] == 8'h00
            |=> (reg_value[c] & w1c_mask(L) & ~$past(io_wdata))
            == ($past(reg_value[c]) & w1c_mask(L) & ~$past(io_wdata)))
            else $error("flag changed by zero");
    end
endmodule

// File: dv/core_model.sv
// Core-side model that issues I/O accesses to the block
`timescale 1ns/1ps
module core_model
    import io_space_pkg::*;
(
    // Core access port
    output io_op_t     io_op,
    output logic [5:0] io_addr,
    output logic [2:0] io_bit,
    output logic [7:0] io_wdata
);
    initial begin
        io_op = OP_NONE;
        io_addr = 6'h00;
        io_bit = 3'h0;
        io_wdata = 8'h00;
    end
    // Reserved locations
    function automatic logic hole(input logic [5:0] a);
        return a <= 6'h02 || (a >= 6'h09 && a <= 6'h0c) ||
            (a >= 6'h19 && a <= 6'h1b) || a == 6'h36 || a == 6'h3c;
    endfunction
    // Implemented bits of port B output, port B direction and stack pointer high; all ones elsewhere
    function automatic logic [7:0] used(input logic [5:0] a);
        case (a)
            PORT_B_OUTPUT, PORT_B_DIRECTION: return 8'h3f;
            STACK_POINTER_HIGH: return 8'h03;
            default: return 8'hff;
        endcase
    endfunction
    // Applies one access for one cycle
    task automatic drive(input io_op_t o, input logic [5:0] a,
                         input logic [2:0] b, input logic [7:0] d);
        io_op = (o == OP_WRITE && hole(a)) ? OP_NONE : o;
        io_addr = a;
        io_bit = b;
        io_wdata = d & used(a);
    endtask
endmodule

// File: dv/test_io_register_space_bit_access.sv
// Self-checking bench for the I/O register space block
`timescale 1ns/1ps
module test_io_register_space_bit_access;
    import io_space_pkg::*;
    typedef struct {int kind; logic [7:0] val;} note_t;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    io_op_t      io_op;
    logic [5:0]  io_addr;
    logic [2:0]  io_bit;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        io_skip;
    logic        io_refused;
    logic [7:0]  periph_rdata [64];
    logic [7:0]  flag_set [64];
    logic [7:0]  reg_value [64];
    logic        look = 1'b0;
    logic [31:0] seed = 32'h0000_0a38;
    logic [5:0]  a;
    logic [7:0]  d;
    logic [7:0]  seen;
    note_t       n;
    note_t       notes [$];
    int          fails = 0;
    int          total_checks = 0;
    string       nm [4] = '{"io_rdata", "io_skip", "io_refused",
                            "reg_value"};

    always #5 core_clk = ~core_clk;

    core_model i_core (.io_op, .io_addr, .io_bit, .io_wdata);
    io_register_space_bit_access i_dut (.core_clk, .rst_b, .io_op,
        .io_addr, .io_bit, .io_wdata, .io_rdata, .io_skip, .io_refused,
        .periph_rdata, .flag_set, .reg_value);

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // One access per cycle; k selects the output to check, -1 none
    task automatic op(input io_op_t o, input logic [5:0] x,
                      input int b, input logic [7:0] w, input int k,
                      input logic [7:0] v);
        @(negedge core_clk);
        i_core.drive(o, x, b[2:0], w);
        look = (k >= 0);
        if (k >= 0) notes.push_back('{k, v});
    endtask

    task automatic rd(input logic [5:0] x, input logic [7:0] v);
        op(OP_NONE, x, 0, 8'h00, 0, v);
    endtask

    task automatic pulse(input logic [5:0] x, input logic [7:0] v);
        op(OP_NONE, x, 0, 8'h00, -1, 8'h00);
        flag_set[x] = v;
        @(negedge core_clk);
        flag_set[x] = 8'h00;
    endtask

    always @(posedge core_clk) begin
        if (look) begin
            n = notes.pop_front();
            seen = n.kind == 0 ? io_rdata :
                n.kind == 3 ? reg_value[io_addr] :
                {7'h00, n.kind == 1 ? io_skip : io_refused};
            total_checks++;
            if (seen !== n.val) begin
                fails++;
                $display("MISMATCH %s expected %h seen %h",
                         nm[n.kind], n.val, seen);
            end
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #50000;
        fails++;
        wrap_up();
    end

    initial begin
        for (int i = 0; i < 64; i++) begin
            periph_rdata[i] = 8'h00;
            flag_set[i] = 8'h00;
        end
        repeat (8) @(negedge core_clk);
        rst_b = 1'b1;
        rd(PORT_B_DIRECTION, STORE_RESET);
        rd(6'h09, 8'h00);
        for (int i = 0; i < 3; i++) begin
            a = GENERAL_PURPOSE_0 + i[5:0];
            d = rnd();
            op(OP_WRITE, a, 0, d, -1, 8'h00);
            rd(a, d);
            for (int j = 0; j < 8; j++) begin
                op(OP_SET_SINGLE_IO_BIT, a, j, rnd(), -1, 8'h00);
                rd(a, d | (8'h01 << j));
                op(OP_SKIP_IF_BIT_SET, a, j, 8'h00, 1, 8'h01);
                op(OP_SKIP_IF_BIT_CLEAR, a, j, 8'h00, 1, 8'h00);
                op(OP_CLR_SINGLE_IO_BIT, a, j, rnd(), -1, 8'h00);
                d = d & ~(8'h01 << j);
                rd(a, d);
                op(OP_SKIP_IF_BIT_CLEAR, a, j, 8'h00, 1, 8'h01);
            end
        end
        d = rnd();
        op(OP_WRITE, DEBUG_DATA, 0, d, -1, 8'h00);
        op(OP_SET_SINGLE_IO_BIT, DEBUG_DATA, 3, 8'h00, 2, 8'h01);
        op(OP_CLR_SINGLE_IO_BIT, DEBUG_DATA, 4, 8'h00, 2, 8'h01);
        op(OP_SKIP_IF_BIT_SET, DEBUG_DATA, 0, 8'h00, 2, 8'h01);
        rd(DEBUG_DATA, d);
        op(OP_SKIP_IF_BIT_CLEAR, DEBUG_DATA, 1, 8'h00, 1, 8'h00);
        d = rnd();
        op(OP_WRITE, PORT_B_OUTPUT, 0, d, -1, 8'h00);
        op(OP_NONE, PORT_B_OUTPUT, 0, 8'h00, 3, d & 8'h3f);
        periph_rdata[COMPARATOR_CONTROL_STATUS] = 8'hff;
        rd(COMPARATOR_CONTROL_STATUS, 8'h20);
        periph_rdata[PORT_B_INPUT_PINS] = rnd();
        rd(PORT_B_INPUT_PINS, periph_rdata[PORT_B_INPUT_PINS] & 8'h3f);
        pulse(SERIAL_IFACE_STATUS, 8'he0);
        rd(SERIAL_IFACE_STATUS, 8'he0);
        op(OP_SET_SINGLE_IO_BIT, SERIAL_IFACE_STATUS, 0, 8'h00, -1, 8'h00);
        rd(SERIAL_IFACE_STATUS, 8'he1);
        op(OP_WRITE, SERIAL_IFACE_STATUS, 0, 8'h40, -1, 8'h00);
        rd(SERIAL_IFACE_STATUS, 8'ha0);
        op(OP_WRITE, SERIAL_IFACE_STATUS, 0, 8'h00, -1, 8'h00);
        rd(SERIAL_IFACE_STATUS, 8'ha0);
        op(OP_SET_SINGLE_IO_BIT, SERIAL_IFACE_STATUS, 7, 8'h00, -1, 8'h00);
        rd(SERIAL_IFACE_STATUS, 8'h20);
        op(OP_CLR_SINGLE_IO_BIT, SERIAL_IFACE_STATUS, 5, 8'h00, -1, 8'h00);
        rd(SERIAL_IFACE_STATUS, 8'h20);
        pulse(TIMER_INTERRUPT_FLAGS, 8'h7e);
        op(OP_WRITE, TIMER_INTERRUPT_FLAGS, 0, 8'h02, -1, 8'h00);
        rd(TIMER_INTERRUPT_FLAGS, 8'h7c);
        op(OP_NONE, 6'h00, 0, 8'h00, -1, 8'h00);
        @(posedge core_clk);
        wrap_up();
    end
endmodule
